// [rtl/opdec_pkg.sv]
// Purpose: Shared types and constants for the logic and move opcode decoder.
// Assumes: One core clock; opcodes arrive with their operand bytes.
// Notes:   Opcode encodings stay literal in the decode table itself.
package opdec_pkg;

  // Instruction lengths in bytes and machine cycles.
  localparam logic [1:0] LEN_ONE   = 2'h1;
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;

  // Direct address of the accumulator special-function register.
  localparam logic [7:0] ACC_SFR_ADDR = 8'he0;
  // Bit of a direct address that selects the special-function space.
  localparam int         SFR_SPACE_BIT = 7;
  // Field positions inside the opcode.
  localparam int         REG_FIELD_MSB = 2;
  localparam int         IND_FIELD_BIT = 0;

  // Values after reset.
  localparam logic [7:0]  BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ONE  = 3'b010,
    ST_TWO  = 3'b100
  } state_t;

  typedef enum logic [3:0] {
    FN_NONE  = 4'h0,
    FN_AND   = 4'h1,
    FN_OR    = 4'h2,
    FN_XOR   = 4'h3,
    FN_CLR   = 4'h4,
    FN_CPL   = 4'h5,
    FN_RL    = 4'h6,
    FN_RLC   = 4'h7,
    FN_RR    = 4'h8,
    FN_RRC   = 4'h9,
    FN_SWAP  = 4'ha,
    FN_MOVE  = 4'hb,
    FN_XCH   = 4'hc,
    FN_LOW_DIGIT_EXCHANGE_OP  = 4'hd
  } func_t;

  typedef enum logic [3:0] {
    SRC_NONE     = 4'h0,
    SRC_ACC      = 4'h1,
    SRC_REG      = 4'h2,
    SRC_DIRECT   = 4'h3,
    SRC_INDIRECT = 4'h4,
    SRC_IMM      = 4'h5,
    SRC_IMM3     = 4'h6,
    SRC_CODE_DP  = 4'h7,
    SRC_CODE_PC  = 4'h8,
    SRC_EXT8     = 4'h9,
    SRC_EXT16    = 4'ha,
    SRC_STACK    = 4'hb
  } src_t;

  typedef enum logic [3:0] {
    DST_NONE     = 4'h0,
    DST_ACC      = 4'h1,
    DST_REG      = 4'h2,
    DST_DIRECT   = 4'h3,
    DST_DIRECT3  = 4'h4,
    DST_INDIRECT = 4'h5,
    DST_EXT8     = 4'h6,
    DST_EXT16    = 4'h7,
    DST_STACK    = 4'h8,
    DST_DATA_POINTER     = 4'h9
  } dst_t;

endpackage

// [rtl/acc_unit.sv]
// Purpose: Byte logic, rotate and move results for the decoder.
// Assumes: Pure combinational; a is the destination value, b the source.
// Notes:   Carry changes only for the rotates through carry.
`timescale 1ns/1ps
module acc_unit (
  // Operation and operands
  input  wire opdec_pkg::func_t func,
  input  wire logic [7:0]       a,
  input  wire logic [7:0]       b,
  input  wire logic             carry_in,
  // Results
  output logic [7:0]            res,
  output logic                  carry_out,
  output logic                  carry_we
);

  always_comb begin
    res       = a;
    carry_out = carry_in;
    carry_we  = 1'b0;
    case (func)
      opdec_pkg::FN_AND:  res = a & b;
      opdec_pkg::FN_OR:   res = a | b;
      opdec_pkg::FN_XOR:  res = a ^ b;
      opdec_pkg::FN_CLR:  res = 8'h00;
      opdec_pkg::FN_CPL:  res = ~a;
      opdec_pkg::FN_RL:   res = {a[6:0], a[7]};
      opdec_pkg::FN_RR:   res = {a[0], a[7:1]};
      opdec_pkg::FN_RLC: begin
        res       = {a[6:0], carry_in};
        carry_out = a[7];
        carry_we  = 1'b1;
      end
      opdec_pkg::FN_RRC: begin
        res       = {carry_in, a[7:1]};
        carry_out = a[0];
        carry_we  = 1'b1;
      end
      opdec_pkg::FN_SWAP: res = {a[3:0], a[7:4]};
      opdec_pkg::FN_MOVE: res = b;
      opdec_pkg::FN_XCH:  res = b;
      opdec_pkg::FN_LOW_DIGIT_EXCHANGE_OP: res = {a[7:4], b[3:0]};
      default:            res = a;
    endcase
  end

endmodule // acc_unit

// [rtl/opdec.sv]
// Purpose: Decode and time logic, rotate, move and exchange opcodes.
// Assumes: Operand bytes and the source byte are valid with op_valid.
// Notes:   Results are captured at acceptance and held until done.
`timescale 1ns/1ps

module opdec (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Instruction in
  input  wire logic        op_valid,
  output logic             op_ready,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  op_byte2,
  input  wire logic [7:0]  op_byte3,
  // Core state in
  input  wire logic [7:0]  acc_in,
  input  wire logic [7:0]  mem_in,
  input  wire logic [7:0]  ri_in,
  input  wire logic [7:0]  sp_in,
  input  wire logic [15:0] data_pointer_in,
  input  wire logic [15:0] pc_in,
  input  wire logic        carry_in,
  // Decode results
  output logic             exec_done,
  output logic             known,
  output logic             illegal,
  output logic [1:0]       len,
  output logic [1:0]       cycles,
  output opdec_pkg::src_t  src,
  output opdec_pkg::dst_t  dst,
  output logic [2:0]       reg_sel,
  output logic             addr_sfr,
  // Addresses and data
  output logic [15:0]      src_addr,
  output logic [7:0]       dst_addr,
  output logic [7:0]       acc_out,
  output logic [7:0]       wr_data,
  output logic             carry_out,
  output logic [7:0]       sp_out,
  output logic [15:0]      data_pointer_out,
  // Write strobes, high in the last cycle only
  output logic             acc_we,
  output logic             wr_we,
  output logic             carry_we,
  output logic             sp_we,
  output logic             data_pointer_we
);

  typedef struct packed {
    opdec_pkg::func_t func;
    opdec_pkg::src_t  src;
    opdec_pkg::dst_t  dst;
    logic [1:0]       len;
    logic [1:0]       cyc;
    logic             wb_src;
    logic             known;
  } dec_t;

  typedef struct packed {
    opdec_pkg::state_t st;
    dec_t              d;
    logic              illegal;
    logic [2:0]        reg_sel;
    logic              addr_sfr;
    logic [15:0]       src_addr;
    logic [7:0]        dst_addr;
    logic [7:0]        acc_out;
    logic [7:0]        wr_data;
    logic              carry_out;
    logic              carry_we;
    logic [7:0]        sp_out;
    logic              sp_we;
    logic [15:0]       data_pointer_out;
  } regs_t;

  regs_t            r_reg;
  regs_t            r_next;
  dec_t             dec;
  logic [7:0]       a_val;
  logic [7:0]       b_val;
  logic [7:0]       unit_res;
  logic             unit_c;
  logic             unit_cwe;
  logic             accept;

  function automatic dec_t mk(input opdec_pkg::func_t f,
                              input opdec_pkg::src_t s,
                              input opdec_pkg::dst_t d,
                              input logic [1:0] l,
                              input logic [1:0] c);
    mk.func   = f;
    mk.src    = s;
    mk.dst    = d;
    mk.len    = l;
    mk.cyc    = c;
    mk.wb_src = 1'b0;
    mk.known  = 1'b1;
  endfunction

  // Opcode table; register forms set bit 3 and use the low three bits.
  always_comb begin
    dec = mk(opdec_pkg::FN_NONE, opdec_pkg::SRC_NONE, opdec_pkg::DST_NONE,
             opdec_pkg::LEN_ONE, opdec_pkg::CYC_ONE);
    dec.known = 1'b0;
    casez (opcode)
      8'h5?, 8'h4?, 8'h6?: begin
        case (opcode[7:4])
          4'h5:    dec.func = opdec_pkg::FN_AND;
          4'h4:    dec.func = opdec_pkg::FN_OR;
          default: dec.func = opdec_pkg::FN_XOR;
        endcase
        dec.known = 1'b1;
        dec.len   = opdec_pkg::LEN_TWO;
        dec.cyc   = opdec_pkg::CYC_ONE;
        if (opcode[3]) begin
          dec.src = opdec_pkg::SRC_REG;
          dec.dst = opdec_pkg::DST_ACC;
          dec.len = opdec_pkg::LEN_ONE;
        end else begin
          case (opcode[2:0])
            3'h2: begin
              dec.src = opdec_pkg::SRC_ACC;
              dec.dst = opdec_pkg::DST_DIRECT;
            end
            3'h3: begin
              dec.src = opdec_pkg::SRC_IMM3;
              dec.dst = opdec_pkg::DST_DIRECT;
              dec.len = opdec_pkg::LEN_THREE;
              dec.cyc = opdec_pkg::CYC_TWO;
            end
            3'h4: begin
              dec.src = opdec_pkg::SRC_IMM;
              dec.dst = opdec_pkg::DST_ACC;
            end
            3'h5: begin
              dec.src = opdec_pkg::SRC_DIRECT;
              dec.dst = opdec_pkg::DST_ACC;
            end
            3'h6, 3'h7: begin
              dec.src = opdec_pkg::SRC_INDIRECT;
              dec.dst = opdec_pkg::DST_ACC;
              dec.len = opdec_pkg::LEN_ONE;
            end
            default: begin
              dec.known = 1'b0;
              dec.func  = opdec_pkg::FN_NONE;
              dec.len   = opdec_pkg::LEN_ONE;
            end
          endcase
        end
      end
      8'he4: dec = mk(opdec_pkg::FN_CLR, opdec_pkg::SRC_ACC,
                      opdec_pkg::DST_ACC, opdec_pkg::LEN_ONE,
                      opdec_pkg::CYC_ONE);
      8'hf4: dec = mk(opdec_pkg::FN_CPL, opdec_pkg::SRC_ACC,
                      opdec_pkg::DST_ACC, opdec_pkg::LEN_ONE,
                      opdec_pkg::CYC_ONE);
      8'h23, 8'h33, 8'h03, 8'h13, 8'hc4: begin
        dec = mk(opdec_pkg::FN_SWAP, opdec_pkg::SRC_ACC, opdec_pkg::DST_ACC,
                 opdec_pkg::LEN_ONE, opdec_pkg::CYC_ONE);
        case (opcode[5:4])
          2'h2:    dec.func = opdec_pkg::FN_RL;
          2'h3:    dec.func = opdec_pkg::FN_RLC;
          2'h0:    dec.func = opdec_pkg::FN_RR;
          2'h1:    dec.func = opdec_pkg::FN_RRC;
          default: dec.func = opdec_pkg::FN_SWAP;
        endcase
        if (opcode[7])
          dec.func = opdec_pkg::FN_SWAP;
      end
      8'he1, 8'hf1, 8'he2, 8'he3, 8'he0: ;
      8'he?: begin
        dec = mk(opdec_pkg::FN_MOVE, opdec_pkg::SRC_REG, opdec_pkg::DST_ACC,
                 opdec_pkg::LEN_ONE, opdec_pkg::CYC_ONE);
        if (opcode == 8'he5) begin
          dec.src = opdec_pkg::SRC_DIRECT;
          dec.len = opdec_pkg::LEN_TWO;
        end else if (!opcode[3])
          dec.src = opdec_pkg::SRC_INDIRECT;
      end
      8'h74: dec = mk(opdec_pkg::FN_MOVE, opdec_pkg::SRC_IMM,
                      opdec_pkg::DST_ACC, opdec_pkg::LEN_TWO,
                      opdec_pkg::CYC_ONE);
      8'hf5: dec = mk(opdec_pkg::FN_MOVE, opdec_pkg::SRC_ACC,
                      opdec_pkg::DST_DIRECT, opdec_pkg::LEN_TWO,
                      opdec_pkg::CYC_ONE);
      8'hf?: dec = mk(opdec_pkg::FN_MOVE, opdec_pkg::SRC_ACC,
                      opcode[3] ? opdec_pkg::DST_REG : opdec_pkg::DST_INDIRECT,
                      opdec_pkg::LEN_ONE, opdec_pkg::CYC_ONE);
      8'ha6, 8'ha7, 8'b1010_1???:
        dec = mk(opdec_pkg::FN_MOVE, opdec_pkg::SRC_DIRECT,
                 opcode[3] ? opdec_pkg::DST_REG : opdec_pkg::DST_INDIRECT,
                 opdec_pkg::LEN_TWO, opdec_pkg::CYC_TWO);
      8'h76, 8'h77, 8'b0111_1???:
        dec = mk(opdec_pkg::FN_MOVE, opdec_pkg::SRC_IMM,
                 opcode[3] ? opdec_pkg::DST_REG : opdec_pkg::DST_INDIRECT,
                 opdec_pkg::LEN_TWO, opdec_pkg::CYC_ONE);
      8'h86, 8'h87, 8'b1000_1???:
        dec = mk(opdec_pkg::FN_MOVE,
                 opcode[3] ? opdec_pkg::SRC_REG : opdec_pkg::SRC_INDIRECT,
                 opdec_pkg::DST_DIRECT, opdec_pkg::LEN_TWO,
                 opdec_pkg::CYC_TWO);
      8'h75: dec = mk(opdec_pkg::FN_MOVE, opdec_pkg::SRC_IMM3,
                      opdec_pkg::DST_DIRECT, opdec_pkg::LEN_THREE,
                      opdec_pkg::CYC_TWO);
      8'h85: dec = mk(opdec_pkg::FN_MOVE, opdec_pkg::SRC_DIRECT,
                      opdec_pkg::DST_DIRECT3, opdec_pkg::LEN_THREE,
                      opdec_pkg::CYC_TWO);
      8'h90: dec = mk(opdec_pkg::FN_NONE, opdec_pkg::SRC_IMM,
                      opdec_pkg::DST_DATA_POINTER, opdec_pkg::LEN_THREE,
                      opdec_pkg::CYC_TWO);
      8'h93, 8'h83:
        dec = mk(opdec_pkg::FN_MOVE,
                 opcode[4] ? opdec_pkg::SRC_CODE_DP : opdec_pkg::SRC_CODE_PC,
                 opdec_pkg::DST_ACC, opdec_pkg::LEN_ONE,
                 opdec_pkg::CYC_TWO);
      8'hc0: dec = mk(opdec_pkg::FN_MOVE, opdec_pkg::SRC_DIRECT,
                      opdec_pkg::DST_STACK, opdec_pkg::LEN_TWO,
                      opdec_pkg::CYC_TWO);
      8'hd0: dec = mk(opdec_pkg::FN_MOVE, opdec_pkg::SRC_STACK,
                      opdec_pkg::DST_DIRECT, opdec_pkg::LEN_TWO,
                      opdec_pkg::CYC_TWO);
      8'hc5, 8'hc6, 8'hc7, 8'b1100_1???: begin
        dec = mk(opdec_pkg::FN_XCH, opdec_pkg::SRC_REG, opdec_pkg::DST_ACC,
                 opdec_pkg::LEN_ONE, opdec_pkg::CYC_ONE);
        dec.wb_src = 1'b1;
        if (opcode == 8'hc5) begin
          dec.src = opdec_pkg::SRC_DIRECT;
          dec.len = opdec_pkg::LEN_TWO;
        end else if (!opcode[3])
          dec.src = opdec_pkg::SRC_INDIRECT;
      end
      8'hd6, 8'hd7: begin
        dec = mk(opdec_pkg::FN_LOW_DIGIT_EXCHANGE_OP, opdec_pkg::SRC_INDIRECT,
                 opdec_pkg::DST_ACC, opdec_pkg::LEN_ONE, opdec_pkg::CYC_ONE);
        dec.wb_src = 1'b1;
      end
      default: ;
    endcase
    // External RAM moves share one pattern: bit 4 of the high nibble
    // selects write, bit 1 selects the eight-bit indirect address.
    if (opcode == 8'he0 || opcode == 8'he2 || opcode == 8'he3)
      dec = mk(opdec_pkg::FN_MOVE,
               opcode[1] ? opdec_pkg::SRC_EXT8 : opdec_pkg::SRC_EXT16,
               opdec_pkg::DST_ACC, opdec_pkg::LEN_ONE,
               opdec_pkg::CYC_TWO);
    if (opcode == 8'hf0 || opcode == 8'hf2 || opcode == 8'hf3)
      dec = mk(opdec_pkg::FN_MOVE, opdec_pkg::SRC_ACC,
               opcode[1] ? opdec_pkg::DST_EXT8 : opdec_pkg::DST_EXT16,
               opdec_pkg::LEN_ONE, opdec_pkg::CYC_TWO);
  end

  // Logic into a direct byte combines the byte itself with A or data.
  always_comb begin
    a_val = acc_in;
    if (dec.dst == opdec_pkg::DST_DIRECT && dec.func != opdec_pkg::FN_MOVE)
      a_val = mem_in;
    case (dec.src)
      opdec_pkg::SRC_ACC:  b_val = acc_in;
      opdec_pkg::SRC_IMM:  b_val = op_byte2;
      opdec_pkg::SRC_IMM3: b_val = op_byte3;
      default:             b_val = mem_in;
    endcase
  end

  acc_unit u_acc_unit (
    .func      (dec.func),
    .a         (a_val),
    .b         (b_val),
    .carry_in  (carry_in),
    .res       (unit_res),
    .carry_out (unit_c),
    .carry_we  (unit_cwe)
  );

  assign op_ready = (r_reg.st != opdec_pkg::ST_ONE) ||
                    (r_reg.d.cyc == opdec_pkg::CYC_ONE);
  assign accept   = op_valid && op_ready;

  always_comb begin
    r_next = r_reg;
    case (r_reg.st)
      opdec_pkg::ST_ONE:
        r_next.st = (r_reg.d.cyc == opdec_pkg::CYC_TWO) ?
                    opdec_pkg::ST_TWO : opdec_pkg::ST_IDLE;
      opdec_pkg::ST_TWO:  r_next.st = opdec_pkg::ST_IDLE;
      opdec_pkg::ST_IDLE: r_next.st = opdec_pkg::ST_IDLE;
      default:            r_next.st = opdec_pkg::ST_IDLE;
    endcase
    if (accept) begin
      r_next.st       = opdec_pkg::ST_ONE;
      r_next.d        = dec;
      r_next.illegal  = !dec.known ||
                        (opcode == 8'he5 &&
                         op_byte2 == opdec_pkg::ACC_SFR_ADDR);
      r_next.reg_sel  = (dec.src == opdec_pkg::SRC_REG ||
                         dec.dst == opdec_pkg::DST_REG) ?
                        opcode[opdec_pkg::REG_FIELD_MSB:0] :
                        {2'h0, opcode[opdec_pkg::IND_FIELD_BIT]};
      r_next.addr_sfr = op_byte2[opdec_pkg::SFR_SPACE_BIT];
      case (dec.src)
        opdec_pkg::SRC_DIRECT:   r_next.src_addr = {8'h00, op_byte2};
        opdec_pkg::SRC_INDIRECT: r_next.src_addr = {8'h00, ri_in};
        opdec_pkg::SRC_EXT8:     r_next.src_addr = {8'h00, ri_in};
        opdec_pkg::SRC_EXT16:    r_next.src_addr = data_pointer_in;
        opdec_pkg::SRC_CODE_DP:
          r_next.src_addr = data_pointer_in + {8'h00, acc_in};
        opdec_pkg::SRC_CODE_PC:
          r_next.src_addr = pc_in + {8'h00, acc_in};
        opdec_pkg::SRC_STACK:    r_next.src_addr = {8'h00, sp_in};
        default:                 r_next.src_addr = opdec_pkg::WORD_RESET;
      endcase
      case (dec.dst)
        opdec_pkg::DST_DIRECT:   r_next.dst_addr = op_byte2;
        opdec_pkg::DST_DIRECT3:  r_next.dst_addr = op_byte3;
        opdec_pkg::DST_INDIRECT: r_next.dst_addr = ri_in;
        opdec_pkg::DST_EXT8:     r_next.dst_addr = ri_in;
        opdec_pkg::DST_STACK:    r_next.dst_addr = sp_in + 8'h01;
        default:                 r_next.dst_addr = opdec_pkg::BYTE_RESET;
      endcase
      r_next.acc_out = unit_res;
      case (dec.func)
        opdec_pkg::FN_XCH:  r_next.wr_data = acc_in;
        opdec_pkg::FN_LOW_DIGIT_EXCHANGE_OP:
          r_next.wr_data = {mem_in[7:4], acc_in[3:0]};
        default:            r_next.wr_data = unit_res;
      endcase
      r_next.carry_out = unit_c;
      r_next.carry_we  = unit_cwe && dec.known;
      r_next.sp_we     = dec.src == opdec_pkg::SRC_STACK ||
                         dec.dst == opdec_pkg::DST_STACK;
      r_next.sp_out    = (dec.dst == opdec_pkg::DST_STACK) ?
                         sp_in + 8'h01 : sp_in - 8'h01;
      r_next.data_pointer_out  = {op_byte2, op_byte3};
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      r_reg       <= '0;
      r_reg.st    <= opdec_pkg::ST_IDLE;
      r_reg.d.len <= opdec_pkg::LEN_ONE;
      r_reg.d.cyc <= opdec_pkg::CYC_ONE;
    end else begin
      r_reg <= r_next;
    end
  end

  // Strobes fire once, in the last machine cycle, so that the partner
  // never sees a write before the fetch of a two-cycle source completes.
  assign exec_done = (r_reg.st == opdec_pkg::ST_TWO) ||
                     (r_reg.st == opdec_pkg::ST_ONE &&
                      r_reg.d.cyc == opdec_pkg::CYC_ONE);
  assign acc_we    = exec_done && r_reg.d.dst == opdec_pkg::DST_ACC;
  assign wr_we     = exec_done && (r_reg.d.wb_src ||
                     (r_reg.d.dst != opdec_pkg::DST_ACC &&
                      r_reg.d.dst != opdec_pkg::DST_NONE &&
                      r_reg.d.dst != opdec_pkg::DST_DATA_POINTER));
  assign carry_we  = exec_done && r_reg.carry_we;
  assign sp_we     = exec_done && r_reg.sp_we;
  assign data_pointer_we   = exec_done && r_reg.d.dst == opdec_pkg::DST_DATA_POINTER;

  assign known     = r_reg.d.known;
  assign illegal   = r_reg.illegal;
  assign len       = r_reg.d.len;
  assign cycles    = r_reg.d.cyc;
  assign src       = r_reg.d.src;
  assign dst       = r_reg.d.dst;
  assign reg_sel   = r_reg.reg_sel;
  assign addr_sfr  = r_reg.addr_sfr;
  assign src_addr  = r_reg.src_addr;
  assign dst_addr  = r_reg.dst_addr;
  assign acc_out   = r_reg.acc_out;
  assign wr_data   = r_reg.wr_data;
  assign carry_out = r_reg.carry_out;
  assign sp_out    = r_reg.sp_out;
  assign data_pointer_out  = r_reg.data_pointer_out;

endmodule // opdec

// [tb/opdec_properties.sv]
// Purpose: Port-level timing checks for the opcode decoder.
// Assumes: Bound to opdec; one core clock, reset active low.
// Notes:   Strobes are judged against exec_done and the accepting edge.
`timescale 1ns/1ps
module opdec_checker (
  // Clock, reset and handshake
  input wire logic        mclk, rst_b, op_valid, op_ready, exec_done,
  // Instruction and core state
  input wire logic [7:0]  opcode, op_byte2, op_byte3, acc_in, sp_in,
  // Results
  input wire logic [7:0]  acc_out, sp_out,
  input wire logic [15:0] data_pointer_out,
  input wire logic [1:0]  len, cycles,
  input wire logic        illegal, acc_we, wr_we, carry_we, sp_we, data_pointer_we
);
  wire take = op_valid && op_ready;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  strobe_needs_done_a: assert property ((acc_we || wr_we || carry_we ||
    sp_we || data_pointer_we) |-> exec_done) else $error("strobe without done");
  and_imm_a: assert property (take && opcode == 8'h54 |=> exec_done &&
    acc_we && len == 2'h2 && cycles == 2'h1 &&
    acc_out == ($past(acc_in) & $past(op_byte2))) else $error("and bad");
  two_cycle_a: assert property (take && opcode == 8'h53 |=>
    !op_ready && !exec_done ##1 exec_done && wr_we && len == 2'h3)
    else $error("and direct timing bad");
  data_pointer_load_a: assert property (take && opcode == 8'h90 |=> ##1
    data_pointer_we && data_pointer_out == {$past(op_byte2, 2), $past(op_byte3, 2)})
    else $error("pointer load bad");
  push_sp_a: assert property (take && opcode == 8'hc0 |=> !sp_we ##1
    sp_we && sp_out == $past(sp_in, 2) + 8'h01) else $error("push bad");
  carry_rot_a: assert property (carry_we |->
    $past(opcode) == 8'h33 || $past(opcode) == 8'h13)
    else $error("carry written by other op");
  swap_acc_a: assert property (take && opcode == 8'hc4 |=> acc_we &&
    acc_out == {$past(acc_in[3:0]), $past(acc_in[7:4])})
    else $error("swap bad");
  acc_self_a: assert property (take && opcode == 8'he5 &&
    op_byte2 == 8'he0 |=> illegal) else $error("self move not flagged");
  ext_write_a: assert property (take && opcode == 8'hf0 |=> !exec_done
    ##1 wr_we && !acc_we && len == 2'h1) else $error("ext write bad");
  cover property (take && opcode == 8'h90);
  cover property (take && opcode == 8'hc0);
  cover property (carry_we);
endmodule // opdec_checker
bind opdec opdec_checker chk (.mclk, .rst_b, .op_valid, .op_ready,
  .exec_done, .opcode, .op_byte2, .op_byte3, .acc_in, .sp_in, .acc_out,
  .sp_out, .data_pointer_out, .len, .cycles, .illegal, .acc_we, .wr_we,
  .carry_we, .sp_we, .data_pointer_we);

// [tb/mem_model.sv]
// Purpose: Behavioural data memory on the decoder's far side.
// Assumes: Read is combinational; writes land on the rising edge.
// Notes:   Preset contents are address xor 5a so reads are predictable.
`timescale 1ns/1ps
module mem_model (
  // Clock
  input wire logic       mclk,
  // Read and write sides
  input wire logic [7:0] rd_addr,
  output logic [7:0]     rd_data,
  input wire logic       wr_we,
  input wire logic [7:0] dst_addr,
  input wire logic [7:0] wr_data
);
  logic [7:0] ram [256];
  initial for (int i = 0; i < 256; i++) ram[i] = 8'(i) ^ 8'h5a;
  assign rd_data = ram[rd_addr];
  always @(posedge mclk) if (wr_we) ram[dst_addr] <= wr_data;
endmodule // mem_model

// [tb/logic_and_move_opcode_decoder_tb.sv]
// Purpose: Self-checking bench for the opcode decoder.
// Assumes: Inputs change at the falling edge; memory byte = addr ^ 5a.
// Notes:   Indirect forms put the pointer value on op_byte2 for the model.
`timescale 1ns/1ps
module logic_and_move_opcode_decoder_tb;
  logic mclk = 0, rst_b = 0, op_valid = 0, carry_in = 0;
  logic [7:0] opcode = 0, op_byte2 = 0, op_byte3 = 0, acc_in = 0;
  logic [7:0] ri_in = 0, sp_in = 0, mem_in;
  logic [15:0] data_pointer_in = 0, pc_in = 0, src_addr, data_pointer_out;
  logic op_ready, exec_done, known, illegal, addr_sfr, carry_out;
  logic acc_we, wr_we, carry_we, sp_we, data_pointer_we;
  logic [1:0] len, cycles;
  logic [2:0] reg_sel;
  logic [7:0] dst_addr, acc_out, wr_data, sp_out;
  opdec_pkg::src_t src;
  opdec_pkg::dst_t dst;
  int err_total = 0, samples_checked = 0, n;
  logic [11:0] tbl [45] = '{12'h5d5, 12'h559, 12'h565, 12'h549, 12'h529,
    12'h53e, 12'h4b5, 12'h459, 12'h475, 12'h449, 12'h429, 12'h43e,
    12'h6e5, 12'h659, 12'h665, 12'h649, 12'h629, 12'h63e, 12'he45,
    12'hf45, 12'h235, 12'h335, 12'h035, 12'h135, 12'hc45, 12'hea5,
    12'he59, 12'he65, 12'h749, 12'hf95, 12'ha8a, 12'h7b9, 12'hf59,
    12'h88a, 12'h85e, 12'h86a, 12'h75e, 12'hf75, 12'ha6a, 12'h769,
    12'h90e, 12'h936, 12'he26, 12'hf06, 12'hc0a};
  always #20 mclk = ~mclk;
  opdec dut (.mclk, .rst_b, .op_valid, .op_ready, .opcode, .op_byte2,
    .op_byte3, .acc_in, .mem_in, .ri_in, .sp_in, .data_pointer_in, .pc_in,
    .carry_in, .exec_done, .known, .illegal, .len, .cycles, .src, .dst,
    .reg_sel, .addr_sfr, .src_addr, .dst_addr, .acc_out, .wr_data,
    .carry_out, .sp_out, .data_pointer_out, .acc_we, .wr_we, .carry_we, .sp_we,
    .data_pointer_we);
  mem_model far (.mclk, .rd_addr(op_byte2), .rd_data(mem_in), .wr_we,
    .dst_addr, .wr_data);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Returns at the falling edge of the done cycle; n counts machine cycles.
  task automatic run(input logic [7:0] op, input logic [7:0] b2,
                     input logic [7:0] b3);
    opcode = op; op_byte2 = b2; op_byte3 = b3; op_valid = 1'b1;
    @(negedge mclk);
    op_valid = 1'b0;
    n = 1;
    while (exec_done !== 1'b1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    if (exec_done !== 1'b1) begin
      err_total++;
      stop_test();
    end
  endtask
  task automatic t_table;
    foreach (tbl[i]) begin
      run(tbl[i][11:4], 8'h30, 8'h12);
      chk(len, tbl[i][3:2]);
      chk(n, tbl[i][1:0]);
      chk(known, 1'b1);
      chk({illegal, addr_sfr}, 2'h0);
      if (tbl[i][7]) chk(reg_sel, tbl[i][6:4]);
    end
  endtask
  task automatic t_logic;
    acc_in = 8'hc3;
    run(8'h44, 8'h5a, 8'h00); chk(acc_out, 8'hdb);
    run(8'h64, 8'h5a, 8'h00); chk(acc_out, 8'h99);
    // Byte 30 was rewritten by the table scenario, so read a clean one.
    run(8'h55, 8'h34, 8'h00); chk(acc_out, 8'h42);
    run(8'h52, 8'h31, 8'h00); chk(wr_data, 8'h43);
    run(8'h43, 8'h32, 8'h0f); chk(wr_data, 8'h6f);
    run(8'h63, 8'h33, 8'hff); chk(wr_data, 8'h96);
    chk(dst_addr, 8'h33);
  endtask
  task automatic t_rot;
    acc_in = 8'h96; carry_in = 1'b1;
    run(8'h23, 8'h00, 8'h00); chk({carry_we, acc_out}, 9'h02d);
    run(8'h33, 8'h00, 8'h00); chk({carry_out, acc_out}, 9'h12d);
    run(8'h03, 8'h00, 8'h00); chk(acc_out, 8'h4b);
    run(8'h13, 8'h00, 8'h00); chk({carry_out, acc_out}, 9'h0cb);
    run(8'hc4, 8'h00, 8'h00); chk(acc_out, 8'h69);
  endtask
  task automatic t_moves;
    run(8'hf5, 8'h40, 8'h00); chk({wr_we, dst_addr}, 9'h140);
    // The model writes on the edge that would accept the next read.
    @(negedge mclk);
    run(8'he5, 8'h40, 8'h00); chk(acc_out, 8'h96);
    run(8'he5, 8'he0, 8'h00); chk({illegal, addr_sfr}, 2'h3);
    run(8'h85, 8'h41, 8'h42); chk({dst_addr, wr_data}, 16'h421b);
    run(8'h90, 8'h12, 8'h34); chk(data_pointer_out, 16'h1234);
    sp_in = 8'h07; data_pointer_in = 16'h1000; pc_in = 16'h2000; ri_in = 8'h50;
    run(8'hc0, 8'h44, 8'h00); chk({dst_addr, sp_out}, 16'h0808);
    run(8'hd0, 8'h44, 8'h00); chk({src_addr, sp_out}, 24'h000706);
    run(8'h93, 8'h00, 8'h00); chk(src_addr, 16'h1096);
    chk({src, dst}, {opdec_pkg::SRC_CODE_DP, opdec_pkg::DST_ACC});
    run(8'h83, 8'h00, 8'h00); chk(src_addr, 16'h2096);
    run(8'he0, 8'h00, 8'h00); chk(src_addr, 16'h1000);
    run(8'he3, 8'h50, 8'h00); chk(src_addr, 16'h0050);
    run(8'hf2, 8'h50, 8'h00); chk({wr_we, dst_addr}, 9'h150);
    // Fresh pointers keep the exchanges clear of earlier writes.
    ri_in = 8'h51; run(8'hc6, 8'h51, 8'h00);
    chk({acc_out, wr_data}, 16'h0b96);
    ri_in = 8'h52; run(8'hd7, 8'h52, 8'h00);
    chk({acc_out, wr_data}, 16'h9806);
  endtask
  initial begin
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    t_table();
    t_logic();
    t_rot();
    t_moves();
    stop_test();
  end
endmodule // logic_and_move_opcode_decoder_tb
